// >>> hw/rsrs_defs.svh
// constants for the rolling shutter row sequencer and its controller
// assumes one 250 MHz system clock on both ends
// Operation
// - separate read row and reset row pointers
// - both pointers step on each row advance but the first of a frame
// - exposure is row gap between both pointers
// - combined drive merges pointers, drives both sides
// - combined when dual flag or variant 1/2
// - default readout is double sampled, fpn corrected
// - repeat read resets once, reads many times
// - repeat read outputs reset level and samples
// - controller supplies pixel rate clock, 31.25 MHz from a 40 MHz target
// - controller pulses frame begin each frame
// - row advance selects row, starts blanking
// - sequencer needs only clock, frame, row pulses
// - pulse placement fixed by the row blanking window constants
// - first slope full frame, second uses shutter
// - read type bit: 0 double, 1 repeat
// - variant field ignored under double sampling
// - bit 4: 0 shutter, 1 both sides
// - exposure held in 12-bit field 11:0
`ifndef RSRS_DEFS_SVH
`define RSRS_DEFS_SVH
// sensor register addresses on the serial load
`define RSRS_REG_SEQ      4'h0
`define RSRS_REG_LINES    4'h2
`define RSRS_REG_EXPO     4'h3
`define RSRS_REG_XSTART   4'h5
`define RSRS_REG_YSTART   4'h6
// sequencer register fields
`define RSRS_SEQ_RR_BIT   0
`define RSRS_SEQ_VAR_LO   1
`define RSRS_SEQ_VAR_HI   2
`define RSRS_SEQ_DUAL_BIT 4
// reset values
`define RSRS_SEQ_RST      12'h100
`define RSRS_LINES_RST    12'hbc6
`define RSRS_EXPO_RST     12'h001
`define RSRS_XSTART_RST   12'h000
`define RSRS_YSTART_RST   12'h000
// row blanking windows, in pixel clocks after row advance
`define RSRS_BLK_SYNC     8'h00
`define RSRS_BLK_LOAD     8'h01
`define RSRS_BLK_RST_LO   8'h02
`define RSRS_BLK_RST_HI   8'h05
`define RSRS_BLK_SEL      8'h06
`define RSRS_BLK_SIG      8'h08
`define RSRS_BLK_RRST_LO  8'h0a
`define RSRS_BLK_RRST_HI  8'h0c
`define RSRS_BLK_SRST     8'h0e
`define RSRS_BLK_END      8'h10
// serial word length and timing
`define RSRS_SER_BITS     16
`define RSRS_SER_HALF     8'h04
// clock rates and derived pixel clock half period, rounded up
`define RSRS_SYS_MHZ      250
`define RSRS_PIX_MHZ      40
`define RSRS_PIX_HALF     ((`RSRS_SYS_MHZ + 2 * `RSRS_PIX_MHZ - 1) / (2 * `RSRS_PIX_MHZ))
// controller pulse positions within a row, in pixel clocks
`define RSRS_FRAME_AT     16'h0000
`define RSRS_ROWADV_AT    16'h0002
// controller bus register offsets
`define RSRS_A_CTRL       8'h00
`define RSRS_A_ROWPER     8'h04
`define RSRS_A_FLINES     8'h08
`define RSRS_A_SERCMD     8'h0c
`define RSRS_A_STATUS     8'h10
`define RSRS_ROWPER_RST   16'h0040
`define RSRS_FLINES_RST   16'h0010
`endif

// >>> hw/rsrs_pkg.sv
// types used by the sensor end of the row sequencer link
package rsrs_pkg;
   typedef enum logic [1:0] {RS_IDLE, RS_BLANK, RS_ACTIVE} rsrs_row_state_t;
   typedef struct packed {
      logic [3:0]  addr;
      logic [11:0] data;
   } rsrs_ser_word_t;
endpackage

// >>> hw/rsrs_link_if.sv
// pins between camera controller and sensor sequencer
// all driven by the controller from flops on its own clock
`timescale 1ns/10ps
`default_nettype none
interface rsrs_link_if;
   logic pixelRateClock;
   logic frameBegin;
   logic rowAdvance;
   logic serClk;
   logic serData;
   logic serLoad;
   modport sensor (input pixelRateClock, frameBegin, rowAdvance, serClk, serData, serLoad);
   modport ctrl (output pixelRateClock, frameBegin, rowAdvance, serClk, serData, serLoad);
endinterface
`default_nettype wire

// >>> hw/rsrs_sensor.sv
// sensor end: row pointers, row blanking sequencer, serial registers
// assumes link pins are asynchronous; each passes two flops first
`timescale 1ns/10ps
`default_nettype none
`include "rsrs_defs.svh"
module rsrs_sensor #(
   parameter int REPEAT_FRAMES = 4
) (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   rsrs_link_if.sensor     link,
   output logic [11:0]     readRow,
   output logic [11:0]     shutterRow,
   output logic [11:0]     resetRowAddr,
   output logic            rowResetPulse,
   output logic            rowSelPulse,
   output logic            driveBothSides,
   output logic            slopeSupplySel,
   output logic            rowSync,
   output logic            colStartLoad,
   output logic [6:0]      colStart,
   output logic            sampleSignal,
   output logic            sampleReset,
   output logic            resetLevelTag,
   output logic            fpnCorrect,
   output logic            repeatReadSelect,
   output logic [1:0]      repeatReadVariant,
   output logic            rowActive
);
   logic [5:0]  sync1;
   logic [5:0]  sync2;
   logic [5:0]  sync3;
   logic        pixRise;
   logic        frameRise;
   logic        rowRise;
   logic        serClkRise;
   logic        serLoadRise;
   logic [15:0] serShift;
   logic [11:0] seqReg;
   logic [11:0] linesReg;
   logic [11:0] expoReg;
   logic [6:0]  xStartReg;
   logic [7:0]  yStartReg;
   logic        combined;
   logic        firstFrame;
   logic        frameFresh;
   logic [7:0]  blankCnt;
   logic [$clog2(REPEAT_FRAMES+1)-1:0] frameIdx;
   logic        inBlank;
   logic        shutterReset;
   logic        readReset;
   logic [11:0] lastRow;
   rsrs_pkg::rsrs_row_state_t state;
   rsrs_pkg::rsrs_ser_word_t  serWord;

   function automatic logic [11:0] nextRow(input logic [11:0] ptr, input logic [11:0] first,
                                           input logic [11:0] last);
      nextRow = (ptr >= last) ? first : 12'(ptr + 12'h001);
   endfunction

   function automatic logic inWin(input logic [7:0] cnt, input logic [7:0] lo,
                                  input logic [7:0] hi);
      inWin = (cnt >= lo) && (cnt <= hi);
   endfunction

   // only sync2 is read by logic; sync3 holds last value for edges
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
         sync3 <= 6'h00;
      end else begin
         sync1 <= {link.pixelRateClock, link.frameBegin, link.rowAdvance,
                   link.serClk, link.serData, link.serLoad};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign pixRise     = sync2[5] & ~sync3[5];
   assign frameRise   = sync2[4] & ~sync3[4];
   assign rowRise     = sync2[3] & ~sync3[3];
   assign serClkRise  = sync2[2] & ~sync3[2];
   assign serLoadRise = sync2[0] & ~sync3[0];
   assign serWord     = serShift;

   // serial shift register, msb first, written on load
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         serShift <= 16'h0000;
      end else if (serClkRise) begin
         serShift <= {serShift[14:0], sync2[1]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         seqReg    <= `RSRS_SEQ_RST;
         linesReg  <= `RSRS_LINES_RST;
         expoReg   <= `RSRS_EXPO_RST;
         xStartReg <= 7'(`RSRS_XSTART_RST);
         yStartReg <= 8'(`RSRS_YSTART_RST);
      end else if (serLoadRise) begin
         unique case (serWord.addr)
            `RSRS_REG_SEQ:    seqReg    <= serWord.data;
            `RSRS_REG_LINES:  linesReg  <= serWord.data;
            `RSRS_REG_EXPO:   expoReg   <= serWord.data;
            `RSRS_REG_XSTART: xStartReg <= serWord.data[6:0];
            `RSRS_REG_YSTART: yStartReg <= serWord.data[7:0];
            default: ;
         endcase
      end
   end

   assign repeatReadSelect  = seqReg[`RSRS_SEQ_RR_BIT];
   assign repeatReadVariant = seqReg[`RSRS_SEQ_VAR_HI:`RSRS_SEQ_VAR_LO];
   // variant only counts under repeat read
   assign combined = seqReg[`RSRS_SEQ_DUAL_BIT]
                   | (repeatReadSelect && (repeatReadVariant == 2'h1
                                           || repeatReadVariant == 2'h2));
   assign lastRow = 12'({4'h0, yStartReg} + linesReg - 12'h001);

   // repeat read groups frames; the first of a group does the reset
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         frameIdx <= '0;
      end else if (frameRise) begin
         frameIdx <= (frameIdx >= REPEAT_FRAMES - 1) ? '0 : frameIdx + 1'b1;
      end
   end
   assign firstFrame = (frameIdx == '0);

   // pointers: reset row leads read row by the exposure
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         readRow    <= 12'h000;
         shutterRow <= 12'h000;
         frameFresh <= 1'b0;
      end else if (frameRise) begin
         readRow    <= {4'h0, yStartReg};
         shutterRow <= (13'({4'h0, yStartReg}) + 13'(expoReg) > 13'(lastRow))
                       ? 12'({4'h0, yStartReg} + expoReg - linesReg)
                       : 12'({4'h0, yStartReg} + expoReg);
         frameFresh <= 1'b1;
      end else if (rowRise) begin
         // first row after frame begin stays on the start row
         if (!frameFresh) begin
            readRow    <= nextRow(readRow, {4'h0, yStartReg}, lastRow);
            shutterRow <= nextRow(shutterRow, {4'h0, yStartReg}, lastRow);
         end
         frameFresh <= 1'b0;
      end
   end

   // row sequencer runs off the three link pulses only
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state    <= rsrs_pkg::RS_IDLE;
         blankCnt <= 8'h00;
      end else if (rowRise) begin
         state    <= rsrs_pkg::RS_BLANK;
         blankCnt <= 8'h00;
      end else if (pixRise) begin
         unique case (state)
            rsrs_pkg::RS_IDLE:   state <= rsrs_pkg::RS_IDLE;
            rsrs_pkg::RS_BLANK: begin
               if (blankCnt == `RSRS_BLK_END) begin
                  state <= rsrs_pkg::RS_ACTIVE;
               end else begin
                  blankCnt <= blankCnt + 8'h01;
               end
            end
            rsrs_pkg::RS_ACTIVE: state <= rsrs_pkg::RS_ACTIVE;
         endcase
      end
   end

   assign inBlank = (state == rsrs_pkg::RS_BLANK);
   // repeat read resets a row only in the first frame of a group
   assign shutterReset = inBlank && !combined && (!repeatReadSelect || firstFrame)
                       && inWin(blankCnt, `RSRS_BLK_RST_LO, `RSRS_BLK_RST_HI);
   assign readReset = inBlank && (!repeatReadSelect || (combined && firstFrame))
                    && inWin(blankCnt, `RSRS_BLK_RRST_LO, `RSRS_BLK_RRST_HI);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rowResetPulse  <= 1'b0;
         resetRowAddr   <= 12'h000;
         slopeSupplySel <= 1'b0;
         driveBothSides <= 1'b0;
         rowSelPulse    <= 1'b0;
      end else begin
         rowResetPulse  <= shutterReset | readReset;
         // merged pointers: the read row is reset from both sides
         resetRowAddr   <= shutterReset ? shutterRow : readRow;
         driveBothSides <= combined;
         // shutter reset from the second supply; the read reset gives full frame
         slopeSupplySel <= shutterReset;
         rowSelPulse    <= inBlank && inWin(blankCnt, `RSRS_BLK_SEL, `RSRS_BLK_SRST);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rowSync      <= 1'b0;
         colStartLoad <= 1'b0;
         colStart     <= 7'h00;
      end else begin
         rowSync      <= inBlank && blankCnt == `RSRS_BLK_SYNC;
         colStartLoad <= inBlank && blankCnt == `RSRS_BLK_LOAD;
         if (inBlank && blankCnt == `RSRS_BLK_LOAD) begin
            colStart <= xStartReg;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sampleSignal  <= 1'b0;
         sampleReset   <= 1'b0;
         resetLevelTag <= 1'b0;
         fpnCorrect    <= 1'b1;
         rowActive     <= 1'b0;
      end else begin
         sampleSignal  <= inBlank && blankCnt == `RSRS_BLK_SIG;
         sampleReset   <= inBlank && blankCnt == `RSRS_BLK_SRST
                          && (!repeatReadSelect || firstFrame);
         resetLevelTag <= inBlank && blankCnt == `RSRS_BLK_SRST
                          && repeatReadSelect && firstFrame;
         fpnCorrect    <= !repeatReadSelect;
         rowActive     <= (state == rsrs_pkg::RS_ACTIVE);
      end
   end
endmodule // rsrs_sensor
`default_nettype wire

// >>> hw/rsrs_ctrl.sv
// controller end: pixel clock, frame and row pulses, serial loader
// software reaches it as a zero wait AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "rsrs_defs.svh"
module rsrs_ctrl (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   rsrs_link_if.ctrl        link
);
   logic        wrPend;
   logic [7:0]  wrAddr;
   logic        run;
   logic [15:0] rowPeriod;
   logic [15:0] frameLines;
   logic [15:0] frameCount;
   logic [7:0]  halfCnt;
   logic        pixRise;
   logic [15:0] pixCnt;
   logic [15:0] rowCnt;
   logic        serBusy;
   logic        serStart;
   logic [5:0]  serStep;
   logic [7:0]  serCnt;
   logic [15:0] serWordReg;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign serStart  = wrPend && wrAddr == `RSRS_A_SERCMD && !serBusy;

   // hsize is always a word here; only the address is latched
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else if (hready) begin
         wrPend <= hsel && htrans[1] && hwrite;
         wrAddr <= haddr[7:0];
         if (hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
               `RSRS_A_CTRL:   hrdata <= {31'h0, run};
               `RSRS_A_ROWPER: hrdata <= {16'h0, rowPeriod};
               `RSRS_A_FLINES: hrdata <= {16'h0, frameLines};
               `RSRS_A_SERCMD: hrdata <= {16'h0, serWordReg};
               `RSRS_A_STATUS: hrdata <= {frameCount, 14'h0, run, serBusy};
               default:        hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         run        <= 1'b0;
         rowPeriod  <= `RSRS_ROWPER_RST;
         frameLines <= `RSRS_FLINES_RST;
      end else if (wrPend) begin
         unique case (wrAddr)
            `RSRS_A_CTRL:   run        <= hwdata[0];
            `RSRS_A_ROWPER: rowPeriod  <= hwdata[15:0];
            `RSRS_A_FLINES: frameLines <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // pixel clock from a divider, free running
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         halfCnt             <= 8'h00;
         link.pixelRateClock <= 1'b0;
      end else if (halfCnt == 8'(`RSRS_PIX_HALF - 1)) begin
         halfCnt             <= 8'h00;
         link.pixelRateClock <= ~link.pixelRateClock;
      end else begin
         halfCnt <= halfCnt + 8'h01;
      end
   end
   assign pixRise = (halfCnt == 8'(`RSRS_PIX_HALF - 1)) && !link.pixelRateClock;

   // pulses change on pixel clock rises and last one pixel period
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pixCnt          <= 16'h0000;
         rowCnt          <= 16'h0000;
         frameCount      <= 16'h0000;
         link.frameBegin <= 1'b0;
         link.rowAdvance <= 1'b0;
      end else if (pixRise) begin
         link.frameBegin <= run && pixCnt == `RSRS_FRAME_AT && rowCnt == 16'h0000;
         link.rowAdvance <= run && pixCnt == `RSRS_ROWADV_AT;
         if (!run) begin
            pixCnt <= 16'h0000;
            rowCnt <= 16'h0000;
         end else if (pixCnt >= rowPeriod - 16'h0001) begin
            pixCnt <= 16'h0000;
            if (rowCnt >= frameLines - 16'h0001) begin
               rowCnt     <= 16'h0000;
               frameCount <= frameCount + 16'h0001;
            end else begin
               rowCnt <= rowCnt + 16'h0001;
            end
         end else begin
            pixCnt <= pixCnt + 16'h0001;
         end
      end
   end

   // serial load: 16 bits msb first, clock low then high, then load
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         serBusy      <= 1'b0;
         serStep      <= 6'h00;
         serCnt       <= 8'h00;
         serWordReg   <= 16'h0000;
         link.serClk  <= 1'b0;
         link.serData <= 1'b0;
         link.serLoad <= 1'b0;
      end else if (serStart) begin
         serBusy      <= 1'b1;
         serStep      <= 6'h00;
         serCnt       <= 8'h00;
         serWordReg   <= hwdata[15:0];
         link.serData <= hwdata[15];
      end else if (serBusy) begin
         if (serCnt == `RSRS_SER_HALF - 8'h01) begin
            serCnt  <= 8'h00;
            serStep <= serStep + 6'h01;
            if (serStep < 6'(2 * `RSRS_SER_BITS - 1)) begin
               link.serClk <= ~serStep[0];
               if (serStep[0]) begin
                  link.serData <= serWordReg[4'(14 - serStep[4:1])];
               end
            end else if (serStep == 6'(2 * `RSRS_SER_BITS - 1)) begin
               link.serClk  <= 1'b0;
               link.serLoad <= 1'b1;
            end else begin
               link.serLoad <= 1'b0;
               serBusy      <= 1'b0;
            end
         end else begin
            serCnt <= serCnt + 8'h01;
         end
      end
   end
endmodule // rsrs_ctrl
`default_nettype wire

// >>> tb/rsrs_link_props.sv
// concurrent checks on the row link and on the sensor end's outputs
// assumes the single sys_clk domain and its synchronous active high reset
`timescale 1ns/10ps
`default_nettype none
module rsrs_link_props (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        pixelRateClock,
   input wire logic        frameBegin,
   input wire logic        rowAdvance,
   input wire logic        serLoad,
   input wire logic [11:0] readRow,
   input wire logic [11:0] shutterRow,
   input wire logic        rowSync,
   input wire logic        colStartLoad,
   input wire logic        rowSelPulse,
   input wire logic        driveBothSides,
   input wire logic        slopeSupplySel,
   input wire logic        resetLevelTag,
   input wire logic        fpnCorrect,
   input wire logic        repeatReadSelect,
   input wire logic [1:0]  repeatReadVariant,
   input wire logic [11:0] resetRowAddr,
   input wire logic        sampleSignal,
   input wire logic        sampleReset
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   AST_PIXCLK: assert property ($rose(pixelRateClock) |=> pixelRateClock [*3] ##1 !pixelRateClock)
      else $error("pixel clock half period wrong");
   AST_FRAME: assert property ($rose(frameBegin) |=> frameBegin [*7] ##1 !frameBegin)
      else $error("frame begin pulse length wrong");
   AST_ROWADV: assert property ($rose(rowAdvance) |-> ##[1:12] $rose(rowSync))
      else $error("row advance gave no row sync");
   AST_LOAD: assert property ($rose(rowSync) |-> ##[6:10] $rose(colStartLoad))
      else $error("column start load misplaced");
   AST_SELECT: assert property ($rose(rowSync) |-> ##[44:52] $rose(rowSelPulse))
      else $error("row select misplaced");
   AST_STEP: assert property ($changed(readRow) |-> $changed(shutterRow))
      else $error("pointers moved apart");
   AST_COMBINED: assert property ($stable({repeatReadSelect, repeatReadVariant}) && repeatReadSelect
      && repeatReadVariant inside {2'd1, 2'd2} |-> driveBothSides)
      else $error("repeat variant did not combine drive");
   AST_NO_SHUTTER: assert property (driveBothSides |-> !slopeSupplySel)
      else $error("shutter reset under combined drive");
   AST_FPN: assert property ($stable(repeatReadSelect) |-> fpnCorrect != repeatReadSelect)
      else $error("fpn correction disagrees with read type");
   AST_TAG: assert property (resetLevelTag |-> repeatReadSelect)
      else $error("reset level tag outside repeat read");
   AST_SERLOAD: assert property ($rose(serLoad) |=> serLoad [*3] ##1 !serLoad)
      else $error("serial load pulse length wrong");
   AST_SHUT_ROW: assert property (slopeSupplySel |-> resetRowAddr == shutterRow)
      else $error("shutter reset on wrong row");
   AST_SAMPLE: assert property ($rose(rowSync) |-> ##[60:68] $rose(sampleSignal))
      else $error("signal sample misplaced");
   AST_LEVEL: assert property (resetLevelTag |-> sampleReset)
      else $error("reset level tag without reset sample");
endmodule // rsrs_link_props
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench: controller and sensor joined by the row link
// assumes both ends share sys_clk and reset; software speaks AHB-Lite
`timescale 1ns/10ps
`default_nettype none
`include "rsrs_defs.svh"
module testbench;
   localparam int RF = 4;
   localparam int ROWP = 32;
   localparam int NLIN = 4;
   localparam int FCYC = ROWP * NLIN * 2 * `RSRS_PIX_HALF;
   localparam logic [11:0] YS = 12'h003;
   localparam logic [11:0] EX = 12'h005;
   typedef struct {logic [31:0] a, wd, exp;} rsrs_row_t;
   logic        sys_clk, reset, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, repeatReadVariant;
   logic [2:0]  hsize;
   logic [11:0] readRow, shutterRow, resetRowAddr;
   logic        rowResetPulse, rowSelPulse, driveBothSides, slopeSupplySel, rowSync, colStartLoad;
   logic [6:0]  colStart;
   logic        sampleSignal, sampleReset, resetLevelTag, fpnCorrect, repeatReadSelect, rowActive;
   int          n_mismatch, total_checks;
   // last row starts a serial send, so expo is loaded during the wait_ser after the table
   rsrs_row_t rows [6] = '{'{32'h4, ROWP, ROWP}, '{32'h8, NLIN, NLIN}, '{32'h0, 32'h0, 32'h0},
      '{32'h14, 32'h5a5a, 32'h0}, '{32'h10, 32'hffff, 32'h0}, '{32'hc, 32'h3005, 32'h3005}};
   rsrs_link_if lnk();
   rsrs_ctrl u_rsrs_ctrl (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(lnk));
   rsrs_sensor #(.REPEAT_FRAMES(RF)) u_rsrs_sensor (.sys_clk(sys_clk), .reset(reset), .link(lnk),
      .readRow(readRow), .shutterRow(shutterRow), .resetRowAddr(resetRowAddr),
      .rowResetPulse(rowResetPulse), .rowSelPulse(rowSelPulse), .driveBothSides(driveBothSides),
      .slopeSupplySel(slopeSupplySel), .rowSync(rowSync), .colStartLoad(colStartLoad),
      .colStart(colStart), .sampleSignal(sampleSignal), .sampleReset(sampleReset),
      .resetLevelTag(resetLevelTag), .fpnCorrect(fpnCorrect), .repeatReadSelect(repeatReadSelect),
      .repeatReadVariant(repeatReadVariant), .rowActive(rowActive));
   rsrs_link_props u_rsrs_link_props (.sys_clk(sys_clk), .reset(reset),
      .pixelRateClock(lnk.pixelRateClock), .frameBegin(lnk.frameBegin),
      .rowAdvance(lnk.rowAdvance), .serLoad(lnk.serLoad), .readRow(readRow),
      .shutterRow(shutterRow), .rowSync(rowSync), .colStartLoad(colStartLoad),
      .rowSelPulse(rowSelPulse), .driveBothSides(driveBothSides), .slopeSupplySel(slopeSupplySel),
      .resetLevelTag(resetLevelTag), .fpnCorrect(fpnCorrect), .repeatReadSelect(repeatReadSelect),
      .repeatReadVariant(repeatReadVariant), .resetRowAddr(resetRowAddr),
      .sampleSignal(sampleSignal), .sampleReset(sampleReset));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // waits on the slave's ready; the bus gives no bound, so this one is ours
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) n_mismatch++;
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wait_ser();
      int n;
      n = 0;
      do begin
         ahb(1'b0, 32'h10, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 150);
      if (rd[0] !== 1'b0) n_mismatch++;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic ser(input logic [15:0] w);
      ahb(1'b1, 32'hc, {16'h0, w});
      wait_ser();
   endtask
   task automatic frame_run(output int nr, output int nt, output int ns);
      nr = 0;
      nt = 0;
      ns = 0;
      @(posedge lnk.frameBegin);
      repeat (FCYC - 8) begin
         @(posedge sys_clk);
         nr += int'(rowResetPulse === 1'b1);
         nt += int'(resetLevelTag === 1'b1);
         ns += int'(slopeSupplySel === 1'b1);
      end
   endtask
   initial begin
      #200000;
      n_mismatch++;
      $display("watchdog expired");
      print_verdict();
   end
   initial begin
      logic [3:0] m;
      int nr, nt, ns, fr, ta;
      {hsel, hwrite, htrans, haddr, hwdata, n_mismatch, total_checks} = '0;
      hsize = 3'b010;
      reset = 1'b1;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check("fpnCorrect", fpnCorrect, 32'h1);
      check("driveBothSides", driveBothSides, 32'h0);
      for (int i = 0; i < 6; i++) begin
         ahb(1'b1, rows[i].a, rows[i].wd);
         ahb(1'b0, rows[i].a, 32'h0);
         check("register", rd, rows[i].exp);
      end
      wait_ser();
      $display("register table done");
      for (int i = 0; i < 16; i++) begin
         m = i[3:0];
         ser({`RSRS_REG_SEQ, 4'h1, 3'h0, m[3], 1'b0, m[2:1], m[0]});
         check("repeatReadSelect", repeatReadSelect, m[0]);
         check("repeatReadVariant", repeatReadVariant, m[2:1]);
         check("fpnCorrect", fpnCorrect, !m[0]);
         check("driveBothSides", driveBothSides, m[3] | (m[0] & (m[2:1] inside {1, 2})));
      end
      $display("mode sweep done");
      ser({`RSRS_REG_YSTART, YS});
      ser({`RSRS_REG_XSTART, 12'h007});
      ser({`RSRS_REG_SEQ, 12'h100});
      ahb(1'b1, 32'h0, 32'h1);
      @(posedge lnk.frameBegin);
      repeat (12) @(posedge sys_clk);
      check("readRow", readRow, YS);
      check("shutterRow", shutterRow, YS + EX);
      for (int k = 0; k < NLIN; k++) begin
         repeat (k ? 106 : 44) @(posedge sys_clk);
         check("readRow", readRow, YS + k[11:0]);
         check("pointerGap", shutterRow - readRow, EX);
         check("colStart", colStart, 32'h7);
         repeat (150) @(posedge sys_clk);
         check("rowActive", rowActive, 32'h1);
      end
      repeat (62) @(posedge sys_clk);
      check("reload", readRow, YS);
      frame_run(nr, nt, ns);
      check("shutterSlope", ns > 0, 32'h1);
      check("rowResets", nr > 0, 32'h1);
      check("levelTag", nt, 32'h0);
      $display("rolling shutter done");
      ahb(1'b1, 32'h0, 32'h0);
      ser({`RSRS_REG_SEQ, 12'h110});
      ahb(1'b1, 32'h0, 32'h1);
      frame_run(nr, nt, ns);
      check("combinedSlope", ns, 32'h0);
      check("combinedResets", nr > 0, 32'h1);
      $display("combined drive done");
      ahb(1'b1, 32'h0, 32'h0);
      ser({`RSRS_REG_SEQ, 12'h101});
      ahb(1'b1, 32'h0, 32'h1);
      fr = 0;
      ta = 0;
      repeat (RF) begin
         frame_run(nr, nt, ns);
         fr += int'(nr > 0);
         ta += nt;
      end
      check("framesWithReset", fr, 32'h1);
      check("levelTagSeen", ta > 0, 32'h1);
      $display("repeat read done");
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check("readRowReset", readRow, 32'h0);
      check("fpnReset", fpnCorrect, 32'h1);
      check("frameBeginReset", lnk.frameBegin, 32'h0);
      ahb(1'b0, 32'h4, 32'h0);
      check("rowPeriodReset", rd, 32'h40);
      check("hresp", hresp, 32'h0);
      $display("second reset done");
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
